// ===== core/lmio_pkg.sv
// constants shared by the four-port i/o block and its register slave
`default_nettype none

package lmio_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [3:0] IDX_PA_DATA = 4'h2; // port_a_data
    localparam logic [3:0] IDX_PA_DIR = 4'h3; // port_a_direction
    localparam logic [3:0] IDX_PB_DATA = 4'h4; // port_b_data
    localparam logic [3:0] IDX_PB_DIR = 4'h5; // port_b_direction
    localparam logic [3:0] IDX_PC_DATA = 4'h6; // port_c_data
    localparam logic [3:0] IDX_PC_DIR = 4'h7; // port_c_direction
    localparam logic [3:0] IDX_PD_DATA = 4'h8; // port_d_data
    localparam logic [3:0] IDX_PD_DIR = 4'h9; // port_d_direction
    localparam logic [3:0] IDX_MISC = 4'hA; // misc_drive_control

    // ****************************************************************
    // reset values and field positions
    // ****************************************************************
    localparam logic [7:0] PORT_RESET = 8'h00; // all data and direction
    localparam logic [1:0] MISC_RESET = 2'h0; // both boost bits off
    localparam int unsigned MISC_PA4_BIT = 1; // pin4_drive_boost
    localparam int unsigned MISC_PA5_BIT = 2; // pin 5 drive boost
    localparam logic [1:0] APB_WORD_ALIGN = 2'h0; // low address bits

    // ****************************************************************
    // physical pins per port
    // ****************************************************************
    localparam int unsigned PA_PINS = 8; // port a pins
    localparam int unsigned PB_PINS = 4; // port b pins
    localparam int unsigned PC_PINS = 2; // port c pins
    localparam int unsigned PD_PINS = 8; // port d pins
    localparam int unsigned PIN_TOTAL = 22; // sum of the above

    // analog channel code; the code equals the port b pin number
    localparam logic [1:0] CH_PIN3 = 2'h3; // shares the infrared input

endpackage : lmio_pkg

`default_nettype wire

// ===== core/lmio_reg_if.sv
// register access carrier between the apb slave and the port logic
`default_nettype none

interface lmio_reg_if;
    logic [3:0] index; // word index of the access
    logic [7:0] wdata; // write byte
    logic wr; // one-cycle write strobe
    logic hit; // index is a mapped register
    logic [7:0] rdata; // read byte for the index

    modport bus (output index, output wdata, output wr,
                 input hit, input rdata);
    modport regs (input index, input wdata, input wr,
                  output hit, output rdata);
endinterface : lmio_reg_if

`default_nettype wire

// ===== core/lmio_pin_sync.sv
// two-flop synchroniser for asynchronous pin levels
`default_nettype none

module lmio_pin_sync #(
    parameter int unsigned WIDTH = 22 // number of pins
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic [WIDTH-1:0] pin_raw, // raw pin levels
    output logic [WIDTH-1:0] pin_level // synchronised levels
);

    // ****************************************************************
    // one two-stage chain per pin; stage one feeds stage two only
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta; // first stage, read by second stage alone
            logic next_meta; // next first stage
            logic next_level; // next second stage
            always_comb begin
                next_meta = pin_raw[i];
                next_level = meta;
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta <= 1'b0;
                    pin_level[i] <= 1'b0;
                end else begin
                    meta <= next_meta;
                    pin_level[i] <= next_level;
                end
            end
        end
    endgenerate

endmodule // lmio_pin_sync

`default_nettype wire

// ===== core/lmio_apb_slave.sv
// apb slave that turns bus transfers into register strobes
`default_nettype none

module lmio_apb_slave
    import lmio_pkg::*;
#(
    parameter int unsigned ADDR_W = 12 // apb address width, above 6
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic [ADDR_W-1:0] paddr, // byte address
    input wire logic psel, // slave select
    input wire logic penable, // access phase
    input wire logic pwrite, // 1 write, 0 read
    input wire logic [31:0] pwdata, // write data
    output logic [31:0] prdata, // read data, registered
    output logic pready, // ready, registered
    output logic pslverr, // unmapped access, registered
    lmio_reg_if.bus rif // register carrier
);

    logic addr_ok; // word aligned and inside the block window
    logic setup; // setup cycle of a transfer
    logic [31:0] next_prdata; // next read data
    logic next_pready; // next ready
    logic next_pslverr; // next error

    // ****************************************************************
    // decode
    // ****************************************************************
    assign addr_ok = (paddr[1:0] == APB_WORD_ALIGN) &&
                     (paddr[ADDR_W-1:6] == '0);
    assign setup = psel && !penable;
    assign rif.index = paddr[5:2];
    assign rif.wdata = pwdata[7:0];
    // writes land only at the edge where pready is sampled high
    assign rif.wr = psel && penable && pready && pwrite &&
                    addr_ok && rif.hit;

    // ready is raised in setup so every access has no wait state
    always_comb begin
        next_pready = setup;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_pslverr = !(addr_ok && rif.hit);
            // unmapped or write: read data shows zero
            if (addr_ok && rif.hit && !pwrite) begin
                next_prdata = {24'h000000, rif.rdata};
            end else begin
                next_prdata = 32'h00000000;
            end
        end
    end

    // register the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule // lmio_apb_slave

`default_nettype wire

// ===== core/lmio_ports.sv
// four-port general purpose i/o with alternate function takeover
//
// The APB slave port is this design's own decision.
`default_nettype none

module lmio_ports
    import lmio_pkg::*;
#(
    parameter int unsigned ADDR_W = 12 // apb address width
) (
    input wire logic pclk, // system clock, 100 MHz
    input wire logic presetn, // async reset, active low
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [PA_PINS-1:0] pa_in, // port a pin levels
    output logic [PA_PINS-1:0] pa_out, // port a drive value
    output logic [PA_PINS-1:0] pa_oe, // port a output enable
    output logic [1:0] pa_high_drive, // 8 mA select, pa5 and pa4
    input wire logic [5:0] pwm_output_enable, // pwm owns pa5:0
    input wire logic [5:0] pwm_level, // pwm output levels
    input wire logic [PB_PINS-1:0] pb_in, // port b pin levels
    output logic [PB_PINS-1:0] pb_out, // port b drive value
    output logic [PB_PINS-1:0] pb_oe, // port b output enable
    input wire logic converter_power_on, // converter powered
    input wire logic [1:0] analog_channel_select, // channel code
    output logic [PB_PINS-1:0] analog_switch_on, // pin to converter
    output logic infrared_preprocessor_en, // infrared input enable
    input wire logic [PC_PINS-1:0] pc_in, // port c pin levels
    output logic [PC_PINS-1:0] pc_out, // port c drive value, low
    output logic [PC_PINS-1:0] pc_oe, // port c pull-low enable
    input wire logic in_circuit_link_active, // link owns port c
    input wire logic [PD_PINS-1:0] pd_in, // port d pin levels
    output logic [PD_PINS-1:0] pd_out, // port d drive value, low
    output logic [PD_PINS-1:0] pd_oe, // port d pull-low enable
    input wire logic i2c_enable, // i2c master enabled
    input wire logic i2c_clock_pull_low, // i2c drives scl low
    input wire logic i2c_data_pull_low, // i2c drives sda low
    output logic master_serial_clock_pin, // scl level to i2c
    output logic master_serial_data_pin, // sda level to i2c
    input wire logic [1:0] display_data_channel_enable, // b, a
    input wire logic [1:0] display_clock_pull_low, // b, a
    input wire logic [1:0] display_data_pull_low, // b, a
    output logic [1:0] display_channel_clock_pin, // b, a levels
    output logic [1:0] display_channel_data_pin // b, a levels
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    lmio_reg_if rif (); // bus to register carrier

    logic [PIN_TOTAL-1:0] pins_s; // all synchronised pin levels
    logic [PA_PINS-1:0] pa_s; // port a levels after sync
    logic [PB_PINS-1:0] pb_s; // port b levels after sync
    logic [PC_PINS-1:0] pc_s; // port c levels after sync
    logic [PD_PINS-1:0] pd_s; // port d levels after sync

    logic [7:0] pa_data, next_pa_data; // port a data latch
    logic [7:0] pa_dir, next_pa_dir; // port a direction bits
    logic [7:0] pb_data, next_pb_data; // port b data latch
    logic [7:0] pb_dir, next_pb_dir; // port b direction bits
    logic [7:0] pc_data, next_pc_data; // port c data latch
    logic [7:0] pc_dir, next_pc_dir; // port c direction bits
    logic [7:0] pd_data, next_pd_data; // port d data latch
    logic [7:0] pd_dir, next_pd_dir; // port d direction bits
    logic [1:0] boost, next_boost; // pa5, pa4 drive boost

    logic [PD_PINS-1:0] pd_takeover; // pins owned by serial blocks
    logic [PD_PINS-1:0] pd_pull; // serial pull-low requests
    logic [PB_PINS-1:0] analog_pick; // pin picked for the converter
    logic [PA_PINS-1:0] pa_alt; // port a pins owned by pwm

    logic [PA_PINS-1:0] next_pa_out, next_pa_oe; // port a drivers
    logic [1:0] next_pa_high_drive; // drive strength
    logic [PB_PINS-1:0] next_pb_out, next_pb_oe; // port b drivers
    logic [PB_PINS-1:0] next_analog_switch_on; // analog switches
    logic next_infrared_en; // infrared enable
    logic [PC_PINS-1:0] next_pc_oe; // port c pull-low
    logic [PD_PINS-1:0] next_pd_oe; // port d pull-low
    logic [5:0] next_serial_level; // levels to the serial blocks

    // ****************************************************************
    // bus slave and pin synchronisers
    // ****************************************************************
    lmio_apb_slave #(
        .ADDR_W (ADDR_W)
    ) u_apb (
        .pclk (pclk),
        .presetn (presetn),
        .paddr (paddr),
        .psel (psel),
        .penable (penable),
        .pwrite (pwrite),
        .pwdata (pwdata),
        .prdata (prdata),
        .pready (pready),
        .pslverr (pslverr),
        .rif (rif.bus)
    );

    lmio_pin_sync #(
        .WIDTH (PIN_TOTAL)
    ) u_sync (
        .pclk (pclk),
        .presetn (presetn),
        .pin_raw ({pd_in, pc_in, pb_in, pa_in}),
        .pin_level (pins_s)
    );

    assign pa_s = pins_s[7:0];
    assign pb_s = pins_s[11:8];
    assign pc_s = pins_s[13:12];
    assign pd_s = pins_s[21:14];

    // ****************************************************************
    // alternate function ownership
    // ****************************************************************
    assign pa_alt = {2'b00, pwm_output_enable};
    assign pd_takeover = {2'b00, // no takeover on pd7:6
        {2{display_data_channel_enable[1]}}, // channel b
        {2{display_data_channel_enable[0]}}, // channel a
        {2{i2c_enable}}}; // i2c master on pd1:0
    assign pd_pull = {2'b00,
        display_data_pull_low[1], display_clock_pull_low[1],
        display_data_pull_low[0], display_clock_pull_low[0],
        i2c_data_pull_low, i2c_clock_pull_low};

    // one-hot pick of the analog pin while the converter is on
    always_comb begin
        analog_pick = '0;
        if (converter_power_on) begin
            analog_pick[analog_channel_select] = 1'b1;
        end
    end

    // ****************************************************************
    // register read mux and decode
    // ****************************************************************
    // input pins and pwm- or serial-owned pins read the sampled level, other output pins the latch
    always_comb begin
        rif.hit = 1'b1;
        rif.rdata = 8'h00;
        if (rif.index == IDX_PA_DATA) begin
            // pwm-owned pins read back like inputs
            rif.rdata = (pa_dir & ~pa_alt & pa_data) |
                        (~(pa_dir & ~pa_alt) & pa_s);
        end else if (rif.index == IDX_PA_DIR) begin
            rif.rdata = pa_dir;
        end else if (rif.index == IDX_PB_DATA) begin
            // bits 7:4 have no pin and read zero
            rif.rdata = {4'h0, (pb_dir[3:0] & pb_data[3:0]) |
                        (~pb_dir[3:0] & pb_s)};
        end else if (rif.index == IDX_PB_DIR) begin
            rif.rdata = pb_dir;
        end else if (rif.index == IDX_PC_DATA) begin
            rif.rdata = {6'h00, (pc_dir[1:0] & pc_data[1:0]) |
                        (~pc_dir[1:0] & pc_s)};
        end else if (rif.index == IDX_PC_DIR) begin
            rif.rdata = pc_dir;
        end else if (rif.index == IDX_PD_DATA) begin
            // serial-owned pins show the pin, as inputs do
            rif.rdata = (pd_dir & ~pd_takeover & pd_data) |
                        (~(pd_dir & ~pd_takeover) & pd_s);
        end else if (rif.index == IDX_PD_DIR) begin
            rif.rdata = pd_dir;
        end else if (rif.index == IDX_MISC) begin
            // reserved bits 7:3 and 0 always read zero
            rif.rdata = {5'h00, boost, 1'b0};
        end else begin
            rif.hit = 1'b0; // unmapped index
        end
    end

    // ****************************************************************
    // register file
    // ****************************************************************
    // a write lands in the latch whatever the pin direction
    always_comb begin
        next_pa_data = pa_data;
        next_pa_dir = pa_dir;
        next_pb_data = pb_data;
        next_pb_dir = pb_dir;
        next_pc_data = pc_data;
        next_pc_dir = pc_dir;
        next_pd_data = pd_data;
        next_pd_dir = pd_dir;
        next_boost = boost;
        if (rif.wr) begin
            if (rif.index == IDX_PA_DATA) begin
                next_pa_data = rif.wdata;
            end else if (rif.index == IDX_PA_DIR) begin
                next_pa_dir = rif.wdata;
            end else if (rif.index == IDX_PB_DATA) begin
                next_pb_data = rif.wdata;
            end else if (rif.index == IDX_PB_DIR) begin
                next_pb_dir = rif.wdata;
            end else if (rif.index == IDX_PC_DATA) begin
                next_pc_data = rif.wdata;
            end else if (rif.index == IDX_PC_DIR) begin
                next_pc_dir = rif.wdata;
            end else if (rif.index == IDX_PD_DATA) begin
                next_pd_data = rif.wdata;
            end else if (rif.index == IDX_PD_DIR) begin
                next_pd_dir = rif.wdata;
            end else if (rif.index == IDX_MISC) begin
                // bit 0 is not stored, so a stray one there is harmless
                next_boost = {rif.wdata[MISC_PA5_BIT],
                              rif.wdata[MISC_PA4_BIT]};
            end
        end
    end

    // registers clear to zero, every port an input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_data <= PORT_RESET;
            pa_dir <= PORT_RESET;
            pb_data <= PORT_RESET;
            pb_dir <= PORT_RESET;
            pc_data <= PORT_RESET;
            pc_dir <= PORT_RESET;
            pd_data <= PORT_RESET;
            pd_dir <= PORT_RESET;
            boost <= MISC_RESET;
        end else begin
            pa_data <= next_pa_data;
            pa_dir <= next_pa_dir;
            pb_data <= next_pb_data;
            pb_dir <= next_pb_dir;
            pc_data <= next_pc_data;
            pc_dir <= next_pc_dir;
            pd_data <= next_pd_data;
            pd_dir <= next_pd_dir;
            boost <= next_boost;
        end
    end

    // ****************************************************************
    // pin drivers
    // ****************************************************************
    // drivers are registered, so a write reaches the pad one edge
    // after it lands; this keeps every pad output glitch free
    always_comb begin
        // port a push-pull: pwm level replaces the latch when owned
        next_pa_out = (pa_alt & {2'b00, pwm_level}) |
                      (~pa_alt & pa_data);
        next_pa_oe = pa_dir | pa_alt;
        // boost counts only while the pin is an output
        next_pa_high_drive = boost & next_pa_oe[5:4];
        // port b push-pull; the analog pin never drives
        next_pb_out = pb_data[3:0];
        next_pb_oe = pb_dir[3:0] & ~analog_pick;
        next_analog_switch_on = analog_pick;
        // shared pin 3 is taken from the infrared input
        next_infrared_en = !(converter_power_on &&
                             analog_channel_select == CH_PIN3);
        // port c open-drain: a one output floats, a zero pulls low;
        // the link keeps the pins while it talks
        next_pc_oe = in_circuit_link_active ? '0 :
                     (pc_dir[1:0] & ~pc_data[1:0]);
        // port d open-drain; serial owners pull low on request
        next_pd_oe = (pd_takeover & pd_pull) |
                     (~pd_takeover & pd_dir & ~pd_data);
        // serial blocks see the sampled pin level
        next_serial_level = pd_s[5:0];
    end

    // register the drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_out <= '0;
            pa_oe <= '0;
            pa_high_drive <= 2'h0;
            pb_out <= '0;
            pb_oe <= '0;
            analog_switch_on <= '0;
            infrared_preprocessor_en <= 1'b1;
            pc_out <= '0;
            pc_oe <= '0;
            pd_out <= '0;
            pd_oe <= '0;
            master_serial_clock_pin <= 1'b0;
            master_serial_data_pin <= 1'b0;
            display_channel_clock_pin <= 2'h0;
            display_channel_data_pin <= 2'h0;
        end else begin
            pa_out <= next_pa_out;
            pa_oe <= next_pa_oe;
            pa_high_drive <= next_pa_high_drive;
            pb_out <= next_pb_out;
            pb_oe <= next_pb_oe;
            analog_switch_on <= next_analog_switch_on;
            infrared_preprocessor_en <= next_infrared_en;
            pc_out <= '0; // open-drain only ever pulls low
            pc_oe <= next_pc_oe;
            pd_out <= '0; // open-drain only ever pulls low
            pd_oe <= next_pd_oe;
            master_serial_clock_pin <= next_serial_level[0];
            master_serial_data_pin <= next_serial_level[1];
            display_channel_clock_pin <= {next_serial_level[4],
                                          next_serial_level[2]};
            display_channel_data_pin <= {next_serial_level[5],
                                         next_serial_level[3]};
        end
    end

endmodule // lmio_ports

`default_nettype wire

// ===== testbench/lmio_ports_assertions.sv
// concurrent checks on the ports of the four-port i/o block
`default_nettype none
module lmio_ports_chk
    import lmio_pkg::*;
#(parameter int unsigned ADDR_W = 12) (
    input wire logic pclk, presetn, psel, penable, pwrite, pready,
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [PA_PINS-1:0] pa_oe, // port a enables
    input wire logic [1:0] pa_high_drive, analog_channel_select,
    input wire logic converter_power_on, infrared_preprocessor_en,
    input wire logic [PB_PINS-1:0] analog_switch_on, // routing
    input wire logic [PC_PINS-1:0] pc_out, pc_oe, // port c drive
    input wire logic in_circuit_link_active, i2c_enable,
    input wire logic i2c_clock_pull_low, i2c_data_pull_low,
    input wire logic [PD_PINS-1:0] pd_out, pd_oe // port d drive
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // checks; the $past(presetn) guards skip the first edge after reset
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_BOOST: assert property (pa_high_drive[0] |-> pa_oe[4])
        else $error("boost on an input pin");
    AST_ANALOG: assert property ($past(presetn) |->
        analog_switch_on == ($past(converter_power_on) ?
        4'h1 << $past(analog_channel_select) : 4'h0))
        else $error("wrong analog routing");
    AST_IR: assert property ($past(presetn) |->
        infrared_preprocessor_en == !($past(converter_power_on) &&
        $past(analog_channel_select) == CH_PIN3))
        else $error("infrared enable wrong");
    AST_PC_LOW: assert property (pc_out == '0)
        else $error("port c drives high");
    AST_LINK: assert property ($past(in_circuit_link_active) &&
        $past(presetn) |-> pc_oe == '0)
        else $error("port c driven under link");
    AST_I2C: assert property ($past(i2c_enable) && $past(presetn) |->
        pd_oe[1:0] == {$past(i2c_data_pull_low), $past(i2c_clock_pull_low)})
        else $error("i2c pins not handed over");
    AST_PD_LOW: assert property (pd_out == '0)
        else $error("port d drives high");
    AST_DIR: assert property (psel && penable && pready && pwrite &&
        paddr == 'h0C |-> ##2 pa_oe[7:6] == $past(pwdata[7:6], 2))
        else $error("direction write late");
    cover property (converter_power_on && analog_channel_select == CH_PIN3);
    cover property (i2c_enable && in_circuit_link_active == 1'b0);
    cover property (in_circuit_link_active);
endmodule // lmio_ports_chk
bind lmio_ports lmio_ports_chk #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

// ===== testbench/lmio_pin_model.sv
// far-side pin model: resolves every pad from device and board
`default_nettype none
module lmio_pin_model (
    input wire logic [21:0] oe, // device drive enables
    input wire logic [21:0] out, // device drive values
    input wire logic [21:0] ext, // board levels, no pull-ups
    output logic [21:0] lvl // resolved pad levels
);
    timeunit 1ns;
    timeprecision 1ns;
    // open-drain pads drive out=0, so one rule serves all ports
    assign lvl = (oe & out) | (~oe & ext);
endmodule // lmio_pin_model
`default_nettype wire

// ===== testbench/lmio_ports_tb_top.sv
// self-checking bench of the four-port i/o block
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    bad_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module lmio_ports_tb_top
    import lmio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    int bad_count = 0, total_checks = 0, p, k;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] r, dv, dt, pa_in, pa_out, pa_oe, pd_in, pd_out, pd_oe;
    logic [3:0] pb_in, pb_out, pb_oe, analog_switch_on;
    logic [1:0] pc_in, pc_out, pc_oe, pa_high_drive, analog_channel_select;
    logic [1:0] display_data_channel_enable, display_clock_pull_low;
    logic [1:0] display_data_pull_low, display_channel_clock_pin;
    logic [1:0] display_channel_data_pin;
    logic [5:0] pwm_output_enable, pwm_level;
    logic converter_power_on, infrared_preprocessor_en, i2c_enable;
    logic in_circuit_link_active, i2c_clock_pull_low, i2c_data_pull_low;
    logic master_serial_clock_pin, master_serial_data_pin;
    logic [21:0] ext; // board levels
    lmio_ports #(.ADDR_W(12)) dut_u (.*);
    lmio_pin_model pm_u (.oe({pd_oe, pc_oe, pb_oe, pa_oe}),
        .out({pd_out, pc_out, pb_out, pa_out}), .ext(ext),
        .lvl({pd_in, pc_in, pb_in, pa_in}));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // apb transfer; answer taken at the edge where pready is seen high
    task automatic xfer(input logic w, input logic [3:0] i,
        input logic [7:0] d);
        @(posedge pclk);
        {psel, penable} <= 2'b10;
        pwrite <= w;
        paddr <= {6'h00, i, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata[7:0];
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // enough edges for synchronisers and registered drivers
    task automatic settle;
        repeat (5) @(posedge pclk);
    endtask
    // read value: latch where driven, pad elsewhere, absent bits zero
    function automatic logic [7:0] exp_rd(int q, logic [7:0] v, t,
        logic [21:0] e);
        logic [7:0] x;
        x = 8'(e >> (q == 0 ? 0 : q == 1 ? 8 : q == 2 ? 12 : 14));
        return ((v & t) | (~v & x)) & (q == 1 ? 8'h0F : q == 2 ? 8'h03 : 8'hFF);
    endfunction
    task automatic close_out;
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #60000;
        bad_count++;
        close_out;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ext} = '0;
        {converter_power_on, analog_channel_select, i2c_enable} = '0;
        {in_circuit_link_active, i2c_clock_pull_low, i2c_data_pull_low} = '0;
        {display_data_channel_enable, display_clock_pull_low} = '0;
        {display_data_pull_low, pwm_output_enable, pwm_level} = '0;
        presetn = 1'b0;
        p = $urandom(78105);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 2; k < 12; k++) begin
            xfer(1'b0, 4'(k), 8'hFF);
            `CHK({err, r}, {k == 11, 8'h00})
        end
        repeat (60) begin
            p = $urandom % 4;
            dv = 8'($urandom);
            dt = 8'($urandom);
            ext <= 22'($urandom);
            xfer(1'b1, 4'(3 + 2 * p), dv);
            xfer(1'b1, 4'(2 + 2 * p), dt);
            settle;
            if (p == 0) `CHK({pa_oe, pa_out}, {dv, dt})
            if (p == 1) `CHK({pb_oe, pb_out}, {dv[3:0], dt[3:0]})
            if (p == 2) `CHK(pc_oe, dv[1:0] & ~dt[1:0])
            if (p == 3) `CHK(pd_oe, dv & ~dt)
            xfer(1'b0, 4'(2 + 2 * p), 8'h00);
            `CHK(r, exp_rd(p, dv, dt, ext))
        end
        xfer(1'b1, IDX_PB_DIR, 8'h0F);
        converter_power_on <= 1'b1;
        for (k = 0; k < 4; k++) begin
            analog_channel_select <= 2'(k); // one line at a time
            settle;
            `CHK(analog_switch_on, 4'h1 << k)
            `CHK(infrared_preprocessor_en, k != 3)
            `CHK(pb_oe, ~(4'h1 << k))
        end
        converter_power_on <= 1'b0;
        xfer(1'b1, IDX_MISC, 8'h02); // reserved bit 0 kept zero
        xfer(1'b1, IDX_PA_DIR, 8'h10);
        settle;
        `CHK(pa_high_drive[0], 1'b1)
        xfer(1'b1, IDX_PA_DIR, 8'h00);
        {pwm_output_enable, pwm_level} <= 12'h410;
        settle;
        `CHK({pa_high_drive[0], pa_oe[4], pa_out[4]}, 3'h7)
        pwm_output_enable <= 6'h00;
        settle;
        `CHK({pa_high_drive[0], pa_oe[4]}, 2'h0)
        xfer(1'b1, IDX_PD_DIR, 8'hC0);
        xfer(1'b1, IDX_PD_DATA, 8'h40);
        {i2c_enable, i2c_clock_pull_low, i2c_data_pull_low} <= 3'h6;
        {display_data_channel_enable, display_clock_pull_low} <= 4'hD;
        display_data_pull_low <= 2'h2;
        ext <= '1;
        settle;
        `CHK(pd_oe, 8'hA5)
        `CHK({master_serial_clock_pin, master_serial_data_pin}, 2'h1)
        `CHK(display_channel_clock_pin, 2'h2)
        `CHK(display_channel_data_pin, 2'h1)
        xfer(1'b1, IDX_PC_DIR, 8'h03);
        xfer(1'b1, IDX_PC_DATA, 8'h00);
        in_circuit_link_active <= 1'b1;
        settle;
        `CHK(pc_oe, 2'h0)
        in_circuit_link_active <= 1'b0;
        settle;
        `CHK(pc_oe, 2'h3)
        close_out;
    end
endmodule // lmio_ports_tb_top
`default_nettype wire
